// File: design/cidbm_pkg.sv
/*
  Constants and types of the extended identifier buffer map.
  Assumes byte addresses on a 32-bit Avalon-MM bus, one register a word.
*/
`default_nettype none

package cidbm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] TX_BASE = 8'h00;
  localparam logic [7:0] RX_BASE = 8'h10;
  localparam logic [7:0] CTRL_ADDR = 8'h20;
  localparam logic [7:0] WORD_STEP = 8'h04;
  localparam int unsigned NUM_BYTES = 4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned SRR_BIT = 4;
  localparam int unsigned IDE_BIT = 3;
  localparam int unsigned EXT_RTR_BIT = 0;
  localparam int unsigned STD_RTR_BIT = 4;
  localparam int unsigned CTL_TXE_BIT = 0;
  localparam int unsigned CTL_RXF_BIT = 1;
  localparam int unsigned CTL_SEL_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic TXE_RST = 1'b1;
  localparam logic RXF_RST = 1'b0;
  localparam logic SEL_RST = 1'b0;
  localparam int unsigned ID_W = 29;
  localparam int unsigned STD_ID_W = 11;
  localparam logic [5:0] EXT_BITS = 6'h20;
  localparam logic [5:0] STD_BITS = 6'h0d;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [28:0] id;
    logic srr;
    logic ide;
    logic rtr;
  } cidbm_rx_frame_s;

  typedef enum logic [0:0] {
    CIDBM_IDLE = 1'b0,
    CIDBM_SHIFT = 1'b1
  } cidbm_tx_state_e;

endpackage : cidbm_pkg

`default_nettype wire

// File: design/cidbm_buffer_map.sv
/*
  One transmit and one receive identifier buffer with extended mapping,
  an Avalon-MM slave for software, a bit serialiser towards the protocol
  engine and a priority compare against the identifier on the bus.
  Assumes the engine presents received frames with a one-cycle strobe
  and takes serial bits with a valid/ready handshake.
*/
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module cidbm_buffer_map (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Serial transmit towards the engine
  output logic tx_bit,
  output logic tx_valid,
  input wire logic tx_ready,
  // Arbitration compare
  input wire logic [28:0] arb_id,
  output logic tx_wins,
  // Received frame from the engine
  input wire logic rx_store,
  input wire cidbm_pkg::cidbm_rx_frame_s rx_frame
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [28:0] ext_id(input logic [7:0] b0,
                                         input logic [7:0] b1,
                                         input logic [7:0] b2,
                                         input logic [7:0] b3);
    ext_id = {b0, b1[7:5], b1[2:0], b2, b3[7:1]};
  endfunction : ext_id

  logic [7:0] tx_byte [cidbm_pkg::NUM_BYTES];
  logic [7:0] rx_byte [cidbm_pkg::NUM_BYTES];
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic tx_empty_reg;
  logic rx_full_reg;
  logic sel_reg;
  cidbm_pkg::cidbm_tx_state_e state_reg;
  logic [31:0] shift_reg;
  logic [5:0] cnt_reg;
  logic [7:0] rd_byte;
  logic req;
  logic wr_en;
  logic ctrl_wr;
  logic tx_wr;
  logic tx_start;
  logic rxf_clr;
  logic rx_take;
  logic tx_ext;
  logic last_bit;
  logic [28:0] tx_id;
  logic [28:0] cur_id;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Every access waits exactly one cycle; read data is registered then.
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata = rdata_reg;
  assign wr_en = avs_write & ack_reg & avs_byteenable[0];
  assign ctrl_wr = wr_en & (avs_address == cidbm_pkg::CTRL_ADDR);
  assign tx_wr = wr_en & tx_empty_reg & sel_reg;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < cidbm_pkg::NUM_BYTES; i++) begin
      if (avs_address == cidbm_pkg::TX_BASE +
          8'(i * cidbm_pkg::WORD_STEP)) begin
        rd_byte = tx_byte[i];
      end
      if (avs_address == cidbm_pkg::RX_BASE +
          8'(i * cidbm_pkg::WORD_STEP)) begin
        rd_byte = rx_byte[i];
      end
    end
    if (avs_address == cidbm_pkg::CTRL_ADDR) begin
      rd_byte = {5'h00, sel_reg, rx_full_reg, tx_empty_reg};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      rdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Control and status flags
  // ----------------------------------------------------------------
  assign tx_start = ctrl_wr & avs_writedata[cidbm_pkg::CTL_TXE_BIT] &
                    tx_empty_reg;
  assign rxf_clr = ctrl_wr & avs_writedata[cidbm_pkg::CTL_RXF_BIT];
  // A frame may land in the same cycle that software frees the buffer.
  assign rx_take = rx_store & (~rx_full_reg | rxf_clr);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sel_reg <= cidbm_pkg::SEL_RST;
    end else if (ctrl_wr) begin
      sel_reg <= avs_writedata[cidbm_pkg::CTL_SEL_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_empty_reg <= cidbm_pkg::TXE_RST;
    end else if (last_bit) begin
      tx_empty_reg <= 1'b1;
    end else if (tx_start) begin
      tx_empty_reg <= 1'b0;
    end
  end

  // Set wins over a clear in the same cycle.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_full_reg <= cidbm_pkg::RXF_RST;
    end else if (rx_take) begin
      rx_full_reg <= 1'b1;
    end else if (rxf_clr) begin
      rx_full_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Identifier storage
  // ----------------------------------------------------------------
  // No reset: contents are undefined until written, as in RAM.
  genvar g;
  generate
    for (g = 0; g < cidbm_pkg::NUM_BYTES; g++) begin : g_tx
      always_ff @(posedge sys_clk) begin
        if (tx_wr && avs_address == cidbm_pkg::TX_BASE +
            8'(g * cidbm_pkg::WORD_STEP)) begin
          tx_byte[g] <= avs_writedata[7:0];
        end
      end
    end
  endgenerate

  // Writes to receive addresses fall through unused.
  always_ff @(posedge sys_clk) begin
    if (rx_take) begin
      if (rx_frame.ide) begin
        rx_byte[0] <= rx_frame.id[28:21];
        rx_byte[1] <= {rx_frame.id[20:18], rx_frame.srr,
                       rx_frame.ide, rx_frame.id[17:15]};
        rx_byte[2] <= rx_frame.id[14:7];
        rx_byte[3] <= {rx_frame.id[6:0], rx_frame.rtr};
      end else begin
        rx_byte[0] <= rx_frame.id[10:3];
        rx_byte[1] <= {rx_frame.id[2:0], rx_frame.rtr,
                       rx_frame.ide, 3'h0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Serialiser
  // ----------------------------------------------------------------
  assign tx_ext = tx_byte[1][cidbm_pkg::IDE_BIT];
  assign tx_id = ext_id(tx_byte[0], tx_byte[1], tx_byte[2], tx_byte[3]);
  assign tx_valid = (state_reg == cidbm_pkg::CIDBM_SHIFT);
  assign tx_bit = shift_reg[31];
  assign last_bit = tx_valid & tx_ready & (cnt_reg == 6'h01);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= cidbm_pkg::CIDBM_IDLE;
    end else begin
      case (state_reg)
        cidbm_pkg::CIDBM_IDLE: begin
          if (tx_start) begin
            state_reg <= cidbm_pkg::CIDBM_SHIFT;
          end
        end
        cidbm_pkg::CIDBM_SHIFT: begin
          if (last_bit) begin
            state_reg <= cidbm_pkg::CIDBM_IDLE;
          end
        end
        default: begin
          state_reg <= cidbm_pkg::CIDBM_IDLE;
        end
      endcase
    end
  end

  // Substitute bit goes out recessive whatever software wrote.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= 32'h0000_0000;
      cnt_reg <= 6'h00;
    end else if (tx_start) begin
      if (tx_ext) begin
        shift_reg <= {tx_id[28:18], 1'b1, 1'b1,
                      tx_id[17:0], tx_byte[3][0]};
        cnt_reg <= cidbm_pkg::EXT_BITS;
      end else begin
        shift_reg <= {tx_byte[0], tx_byte[1][7:5],
                      tx_byte[1][cidbm_pkg::STD_RTR_BIT], 1'b0, 19'h0};
        cnt_reg <= cidbm_pkg::STD_BITS;
      end
    end else if (tx_valid && tx_ready) begin
      shift_reg <= {shift_reg[30:0], 1'b0};
      cnt_reg <= cnt_reg - 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration compare
  // ----------------------------------------------------------------
  // Standard identifiers sit in the top eleven bits for comparison.
  assign cur_id = tx_ext ? tx_id : {tx_byte[0], tx_byte[1][7:5], 18'h0};
  assign tx_wins = tx_valid & (cur_id < arb_id);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_wait_one;
    @(posedge sys_clk) disable iff (!resetn)
    (req && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest held more than one cycle");

  property p_rx_id;
    @(posedge sys_clk) disable iff (!resetn)
    (rx_take && rx_frame.ide) |=>
      ext_id(rx_byte[0], rx_byte[1], rx_byte[2], rx_byte[3])
        == $past(rx_frame.id);
  endproperty
  a_rx_id: assert property (p_rx_id)
    else $error("received identifier mapped wrongly");

  property p_rx_srr;
    @(posedge sys_clk) disable iff (!resetn)
    (rx_take && rx_frame.ide) |=>
      rx_byte[1][cidbm_pkg::SRR_BIT] == $past(rx_frame.srr);
  endproperty
  a_rx_srr: assert property (p_rx_srr)
    else $error("substitute bit not stored as received");

  property p_rx_ide;
    @(posedge sys_clk) disable iff (!resetn)
    rx_take |=> rx_byte[1][cidbm_pkg::IDE_BIT] == $past(rx_frame.ide);
  endproperty
  a_rx_ide: assert property (p_rx_ide)
    else $error("format bit not stored as received");

  property p_rx_rtr;
    @(posedge sys_clk) disable iff (!resetn)
    (rx_take && rx_frame.ide) |=>
      rx_byte[3][cidbm_pkg::EXT_RTR_BIT] == $past(rx_frame.rtr);
  endproperty
  a_rx_rtr: assert property (p_rx_rtr)
    else $error("remote bit not stored in bit 0");

  property p_msb_first;
    @(posedge sys_clk) disable iff (!resetn)
    tx_start |=> tx_valid && tx_bit == $past(tx_byte[0][7]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("first bit is not the top identifier bit");

  property p_format_len;
    @(posedge sys_clk) disable iff (!resetn)
    tx_start |=> cnt_reg == ($past(tx_ext) ?
      cidbm_pkg::EXT_BITS : cidbm_pkg::STD_BITS);
  endproperty
  a_format_len: assert property (p_format_len)
    else $error("frame length does not follow format bit");

  // Remote bit is last of an extended frame, next to last of a standard one.
  property p_tx_rtr;
    @(posedge sys_clk) disable iff (!resetn)
    (tx_valid && cnt_reg == (tx_ext ? 6'h01 : 6'h02)) |->
      tx_bit == (tx_ext ? tx_byte[3][cidbm_pkg::EXT_RTR_BIT] :
      tx_byte[1][cidbm_pkg::STD_RTR_BIT]);
  endproperty
  a_tx_rtr: assert property (p_tx_rtr)
    else $error("sent remote bit differs from programmed");

  // Counted by bits left, so a slow engine does not shift the check.
  property p_ext_flags;
    @(posedge sys_clk) disable iff (!resetn)
    (tx_valid && tx_ext && (cnt_reg == 6'h15 || cnt_reg == 6'h14)) |->
      tx_bit;
  endproperty
  a_ext_flags: assert property (p_ext_flags)
    else $error("substitute or format bit not recessive");

  property p_prio;
    @(posedge sys_clk) disable iff (!resetn)
    (arb_id == 29'h0000_0000) |-> !tx_wins;
  endproperty
  a_prio: assert property (p_prio)
    else $error("zero identifier lost arbitration");

  property p_no_write_busy;
    @(posedge sys_clk) disable iff (!resetn)
    !tx_empty_reg |=> $stable(tx_id);
  endproperty
  a_no_write_busy: assert property (p_no_write_busy)
    else $error("transmit identifier changed while busy");

endmodule : cidbm_buffer_map

`default_nettype wire

// File: verification/cidbm_engine_model.sv
/*
  Stand-in for the protocol engine: takes serial identifier bits and
  offers received frames. Assumes the buffer map's valid/ready serial
  port and its one-cycle frame store strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module cidbm_engine_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial side
  input wire logic tx_bit,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic slow,
  // Receive side
  output var logic rx_store,
  output var cidbm_pkg::cidbm_rx_frame_s rx_frame,
  // Observation
  output logic [63:0] bits,
  output logic [7:0] cnt
);
  logic busy;
  logic phase;

  // Slow mode takes a bit only every other cycle
  assign tx_ready = slow ? phase : 1'b1;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      phase <= 1'b0;
      cnt <= 8'h00;
      bits <= 64'h0;
    end else begin
      phase <= ~phase;
      if (tx_valid && tx_ready) begin
        bits <= busy ? {bits[62:0], tx_bit} : {63'h0, tx_bit};
        cnt <= busy ? cnt + 8'h01 : 8'h01;
        busy <= 1'b1;
      end else if (!tx_valid) begin
        busy <= 1'b0;
      end
    end
  end

  initial begin
    rx_store = 1'b0;
    rx_frame = '0;
  end

  task automatic send_frame(input cidbm_pkg::cidbm_rx_frame_s f);
    rx_frame <= f;
    rx_store <= 1'b1;
    @(posedge sys_clk);
    rx_store <= 1'b0;
    // Stale lines must not pass for the frame just stored
    rx_frame <= ~f;
  endtask : send_frame
endmodule : cidbm_engine_model

`default_nettype wire

// File: verification/cidbm_buffer_map_tb.sv
/*
  Self-checking bench for the identifier buffer map.
  Assumes the register map of the package; the bus task waits for
  waitrequest low however long it takes, up to its own limit.
*/
`timescale 1ns/1ps
`default_nettype none

module cidbm_buffer_map_tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic tx_bit, tx_valid, tx_ready, tx_wins, rx_store, slow = 1'b0;
  logic [28:0] arb_id = 29'h0;
  cidbm_pkg::cidbm_rx_frame_s rx_frame;
  logic [63:0] bits;
  logic [7:0] cnt;
  logic [31:0] rd;
  int bad_count = 0;
  int checks = 0;
  localparam logic [28:0] XID = 29'h0a5c3f1;
  localparam logic [10:0] SID = 11'h5a3;

  always #50 sys_clk = ~sys_clk;

  cidbm_buffer_map u_dut (.sys_clk(sys_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(4'h1), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_bit(tx_bit), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .arb_id(arb_id), .tx_wins(tx_wins), .rx_store(rx_store),
    .rx_frame(rx_frame));

  cidbm_engine_model u_eng (.sys_clk(sys_clk), .resetn(resetn),
    .tx_bit(tx_bit), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow),
    .rx_store(rx_store), .rx_frame(rx_frame), .bits(bits), .cnt(cnt));

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Waitrequest and read data are taken as they stand at the rising edge;
  // the request is held until an edge sees waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) chk("bus answer", 32'h1, 32'h0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
    bus(1'b0, a, 8'h00, rd);
    chk(what, rd, {24'h0, exp});
  endtask : rd_chk

  task automatic wait_tx_done();
    int n;
    n = 0;
    while (tx_valid === 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 200) chk("tx done", 32'h1, 32'h0);
    @(posedge sys_clk);
  endtask : wait_tx_done

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    // ----------------------------------------------------------------
    // Extended transmit
    // ----------------------------------------------------------------
    rd_chk("ctrl reset", 8'h20, 8'h01);
    bus(1'b1, 8'h20, 8'h04, rd);
    bus(1'b1, 8'h00, XID[28:21], rd);
    bus(1'b1, 8'h04, {XID[20:18], 2'b11, XID[17:15]}, rd);
    bus(1'b1, 8'h08, XID[14:7], rd);
    bus(1'b1, 8'h0c, {XID[6:0], 1'b1}, rd);
    bus(1'b1, 8'h20, 8'h00, rd);
    bus(1'b1, 8'h08, 8'hff, rd);
    bus(1'b1, 8'h20, 8'h04, rd);
    rd_chk("tx byte2", 8'h08, XID[14:7]);
    rd_chk("tx byte1", 8'h04, {XID[20:18], 2'b11, XID[17:15]});
    slow <= 1'b1;
    arb_id <= XID + 29'h1;
    bus(1'b1, 8'h20, 8'h05, rd);
    @(negedge sys_clk);
    chk("wins lower", tx_wins, 1'b1);
    @(posedge sys_clk);
    arb_id <= XID;
    @(negedge sys_clk);
    chk("wins equal", tx_wins, 1'b0);
    @(posedge sys_clk);
    bus(1'b1, 8'h00, 8'h00, rd);
    wait_tx_done();
    chk("ext count", cnt, 8'd32);
    chk("ext bits", bits[31:0], {XID[28:18], 2'b11, XID[17:0], 1'b1});
    rd_chk("tx byte0 kept", 8'h00, XID[28:21]);
    $display("test extended transmit done");
    // ----------------------------------------------------------------
    // Standard transmit, remote frame
    // ----------------------------------------------------------------
    slow <= 1'b0;
    bus(1'b1, 8'h00, SID[10:3], rd);
    bus(1'b1, 8'h04, {SID[2:0], 5'h10}, rd);
    bus(1'b1, 8'h20, 8'h05, rd);
    wait_tx_done();
    chk("std count", cnt, 8'd13);
    chk("std bits", bits[12:0], {SID, 2'b10});
    $display("test standard transmit done");
    // ----------------------------------------------------------------
    // Receive, extended then standard
    // ----------------------------------------------------------------
    u_eng.send_frame({XID, 3'b110});
    @(posedge sys_clk);
    rd_chk("rx full", 8'h20, 8'h07);
    rd_chk("rx byte0", 8'h10, XID[28:21]);
    rd_chk("rx byte1", 8'h14, {XID[20:18], 2'b11, XID[17:15]});
    rd_chk("rx byte2", 8'h18, XID[14:7]);
    rd_chk("rx byte3", 8'h1c, {XID[6:0], 1'b0});
    bus(1'b1, 8'h10, 8'h00, rd);
    rd_chk("rx ro", 8'h10, XID[28:21]);
    rd_chk("unmapped", 8'h30, 8'h00);
    bus(1'b1, 8'h20, 8'h06, rd);
    u_eng.send_frame({XID, 3'b011});
    @(posedge sys_clk);
    rd_chk("rx srr", 8'h14, {XID[20:18], 2'b01, XID[17:15]});
    rd_chk("rx rtr", 8'h1c, {XID[6:0], 1'b1});
    bus(1'b1, 8'h20, 8'h06, rd);
    u_eng.send_frame({18'h0, SID, 3'b101});
    @(posedge sys_clk);
    rd_chk("rx std0", 8'h10, SID[10:3]);
    rd_chk("rx std1", 8'h14, {SID[2:0], 5'h10});
    $display("test receive done");
    wrap_up();
  end
endmodule : cidbm_buffer_map_tb

`default_nettype wire
